// ==== verilog/gdcfg_regs.sv ====
// module: gate driver configuration register bank with wishbone slave, watchdog and interrupt
// What this block does
// - watchdog is off after reset and runs only while its enable bit is set
// - watchdog timeout code 00..11 gives 10, 20, 50, 100 ms; reset 00
// - three-bit gate current field sets source and sink strength; resets to 111
// - sense-output clamp bit limits sense output to 3.6 V; clear at reset
// - three-bit overcurrent threshold applies to every FET; reset code 111
// - four per-FET monitor disable bits; all monitors enabled after reset
// - chop off-time code gives 25, 50, 100, 200 us; reset 00
// - regulation on by default, stopped while regulation-off bit set
// - reference scaled 100, 75, 50, 25 percent for codes 00..11; reset 00
// - sample-hold enable runs shunt amp in sample-and-hold; cleared at reset
// - shunt gain code 00..11 gives 10, 19.8, 39.4, 78 V/V; reset 01
// - while locked, writes to the three config registers are ignored
//
// The Wishbone slave port was chosen for this implementation.
`default_nettype none
module gdcfg_regs #(
  parameter int WD_UNIT_CYCLES = 100000  // cycles per millisecond at 100 MHz
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire gdcfg_pkg::gdcfg_wb_req_t wb_req,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        wb_err_o,
  output gdcfg_pkg::gdcfg_drive_t     drive_cfg,
  output logic                        wdog_fault,
  output logic                        irq
);
  import gdcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]      main_reg;
    logic [7:0]      gatewd_reg;
    logic [7:0]      drain_reg;
    logic [7:0]      chop_reg;
    logic [1:0]      stat_reg;
    logic [1:0]      mask_reg;
    logic [31:0]     rdata_reg;
    logic            ack_reg;
    logic            err_reg;
    gdcfg_wd_state_t wd_state;
    logic [31:0]     wd_cnt;
    logic [6:0]      wd_ms;
    logic            wd_fault;
  } gdcfg_state_t;

  gdcfg_state_t st_reg;
  gdcfg_state_t st_next;

  function automatic logic [6:0] wd_limit_ms(input logic [1:0] code);
    case (code)
      2'h0:    wd_limit_ms = 7'(GDCFG_WD_MS_0);
      2'h1:    wd_limit_ms = 7'(GDCFG_WD_MS_1);
      2'h2:    wd_limit_ms = 7'(GDCFG_WD_MS_2);
      default: wd_limit_ms = 7'(GDCFG_WD_MS_3);
    endcase
  endfunction : wd_limit_ms

  function automatic logic [7:0] dead_cycles(input logic [1:0] code);
    case (code)
      2'h0:    dead_cycles = 8'(GDCFG_DEAD_CYC_0);
      2'h1:    dead_cycles = 8'(GDCFG_DEAD_CYC_1);
      2'h2:    dead_cycles = 8'(GDCFG_DEAD_CYC_2);
      default: dead_cycles = 8'(GDCFG_DEAD_CYC_3);
    endcase
  endfunction : dead_cycles

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [7:0] idx;
  logic       req;
  logic       hit;
  logic       locked;
  logic       wr_ok;
  logic       wdog_enable;
  logic       wd_timeout;
  logic [1:0] events;

  assign idx    = wb_req.adr[9:2];
  assign req    = wb_req.cyc && wb_req.stb && !st_reg.ack_reg && !st_reg.err_reg;
  assign hit    = (wb_req.adr[1:0] == 2'h0) && (wb_req.adr[31:10] == 22'h0) &&
                  (idx >= GDCFG_IDX_MAIN) && (idx <= GDCFG_IDX_LIVE);
  assign locked = (st_reg.main_reg[GDCFG_LOCK_LSB +: 3] == GDCFG_LOCK_CODE);
  assign wr_ok  = req && hit && wb_req.we && wb_req.sel[0];
  assign wdog_enable  = st_reg.gatewd_reg[5];
  assign wd_timeout = (st_reg.wd_state == GDCFG_WD_RUN) && (st_reg.wd_cnt == 32'(WD_UNIT_CYCLES - 1)) &&
                      (st_reg.wd_ms == wd_limit_ms(st_reg.gatewd_reg[4:3]) - 7'h1);

  always_comb begin
    st_next = st_reg;
    events  = 2'h0;
    st_next.ack_reg = req && hit;
    st_next.err_reg = req && !hit;

    // lock field: only the exact code flips it, other patterns leave it
    if (wr_ok && idx == GDCFG_IDX_MAIN) begin
      if (!locked && wb_req.dat[5:3] == GDCFG_LOCK_CODE) begin
        st_next.main_reg[5:3] = GDCFG_LOCK_CODE;
      end else if (locked && wb_req.dat[5:3] == GDCFG_UNLOCK_CODE) begin
        st_next.main_reg[5:3] = GDCFG_UNLOCK_CODE;
      end
      st_next.main_reg[7:6] = wb_req.dat[7:6];
      st_next.main_reg[2:0] = wb_req.dat[2:0];
    end

    if (wr_ok && !locked) begin
      case (idx)
        GDCFG_IDX_GATEWD: st_next.gatewd_reg = wb_req.dat[7:0];
        GDCFG_IDX_DRAIN:  st_next.drain_reg  = wb_req.dat[7:0];
        GDCFG_IDX_CHOP:   st_next.chop_reg   = wb_req.dat[7:0];
        default: ;
      endcase
    end
    if (wr_ok && locked && (idx == GDCFG_IDX_GATEWD || idx == GDCFG_IDX_DRAIN || idx == GDCFG_IDX_CHOP)) begin
      events[GDCFG_EV_LOCKED] = 1'b1;
    end
    if (wr_ok && idx == GDCFG_IDX_MASK) begin
      st_next.mask_reg = wb_req.dat[1:0];
    end

    // watchdog: a write to the kick register restarts the count
    case (st_reg.wd_state)
      GDCFG_WD_IDLE: begin
        st_next.wd_cnt = 32'h0;
        st_next.wd_ms  = 7'h0;
        if (wdog_enable) begin
          st_next.wd_state = GDCFG_WD_RUN;
        end
      end
      GDCFG_WD_RUN: begin
        if (!wdog_enable) begin
          st_next.wd_state = GDCFG_WD_IDLE;
        end else if ((wr_ok && idx == GDCFG_IDX_WDKICK) || wd_timeout) begin
          st_next.wd_cnt = 32'h0;
          st_next.wd_ms  = 7'h0;
        end else if (st_reg.wd_cnt == 32'(WD_UNIT_CYCLES - 1)) begin
          st_next.wd_cnt = 32'h0;
          st_next.wd_ms  = st_reg.wd_ms + 7'h1;
        end else begin
          st_next.wd_cnt = st_reg.wd_cnt + 32'h1;
        end
      end
      default: st_next.wd_state = GDCFG_WD_IDLE;
    endcase
    if (wd_timeout) begin
      st_next.wd_fault = 1'b1;
      events[GDCFG_EV_WDOG] = 1'b1;
    end else if (wr_ok && idx == GDCFG_IDX_MAIN && wb_req.dat[0]) begin
      st_next.wd_fault = 1'b0;
    end

    // status: read clears, but a same-cycle event survives
    if (req && hit && !wb_req.we && idx == GDCFG_IDX_STAT) begin
      st_next.stat_reg = events;
    end else begin
      st_next.stat_reg = st_reg.stat_reg | events;
    end

    st_next.rdata_reg = 32'h0;
    if (req && hit && !wb_req.we) begin
      case (idx)
        GDCFG_IDX_MAIN:   st_next.rdata_reg = {24'h0, st_reg.main_reg & 8'h3e};
        GDCFG_IDX_GATEWD: st_next.rdata_reg = {24'h0, st_reg.gatewd_reg};
        GDCFG_IDX_DRAIN:  st_next.rdata_reg = {24'h0, st_reg.drain_reg};
        GDCFG_IDX_CHOP:   st_next.rdata_reg = {24'h0, st_reg.chop_reg};
        GDCFG_IDX_STAT:   st_next.rdata_reg = {30'h0, st_reg.stat_reg};
        GDCFG_IDX_MASK:   st_next.rdata_reg = {30'h0, st_reg.mask_reg};
        GDCFG_IDX_LIVE:   st_next.rdata_reg = {23'h0, st_reg.wd_ms, st_reg.wd_fault, locked};
        default:          st_next.rdata_reg = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg.main_reg   <= GDCFG_RST_MAIN;
      st_reg.gatewd_reg <= GDCFG_RST_GATEWD;
      st_reg.drain_reg  <= GDCFG_RST_DRAIN;
      st_reg.chop_reg   <= GDCFG_RST_CHOP;
      st_reg.stat_reg   <= 2'h0;
      st_reg.mask_reg   <= 2'h0;
      st_reg.rdata_reg  <= 32'h0;
      st_reg.ack_reg    <= 1'b0;
      st_reg.err_reg    <= 1'b0;
      st_reg.wd_state   <= GDCFG_WD_IDLE;
      st_reg.wd_cnt     <= 32'h0;
      st_reg.wd_ms      <= 7'h0;
      st_reg.wd_fault   <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_dat_o = st_reg.rdata_reg;
  assign wb_ack_o = st_reg.ack_reg;
  assign wb_err_o = st_reg.err_reg;
  assign wdog_fault = st_reg.wd_fault;
  assign irq = |(st_reg.stat_reg & st_reg.mask_reg);

  assign drive_cfg.dead_time_cycles          = dead_cycles(st_reg.gatewd_reg[7:6]);
  assign drive_cfg.gate_current_sel          = st_reg.gatewd_reg[2:0];
  assign drive_cfg.sense_out_clamp           = st_reg.drain_reg[7];
  assign drive_cfg.overcurrent_threshold_sel = st_reg.drain_reg[6:4];
  assign drive_cfg.monitor_enable            = ~st_reg.drain_reg[3:0];
  assign drive_cfg.chop_off_time_sel         = st_reg.chop_reg[7:6];
  assign drive_cfg.regulation_on             = ~st_reg.chop_reg[5];
  assign drive_cfg.vref_scale_sel            = st_reg.chop_reg[4:3];
  assign drive_cfg.sample_hold_enable        = st_reg.chop_reg[2];
  assign drive_cfg.amp_gain_sel              = st_reg.chop_reg[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_locked_write_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && locked && idx == GDCFG_IDX_DRAIN) |=> $stable(st_reg.drain_reg))
    else $error("drain register changed while locked");
  a_unlocked_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && !locked && idx == GDCFG_IDX_DRAIN) |=>
      drive_cfg.overcurrent_threshold_sel == $past(wb_req.dat[6:4]))
    else $error("threshold write lost");
  a_wdog_idle_off: assert property (@(posedge ref_clk) disable iff (reset)
    !wdog_enable |-> ##1 (!clk_en || st_reg.wd_state == GDCFG_WD_IDLE || wdog_enable))
    else $error("watchdog running while disabled");
  // an idle timer must hold a cleared count, so a later enable starts from zero
  a_wdog_idle_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && st_reg.wd_state == GDCFG_WD_IDLE) |=> (st_reg.wd_cnt == 32'h0 && st_reg.wd_ms == 7'h0))
    else $error("idle watchdog count not cleared");
  a_wdog_limit: assert property (@(posedge ref_clk) disable iff (reset)
    wd_timeout |-> st_reg.wd_ms + 7'h1 == wd_limit_ms(st_reg.gatewd_reg[4:3]))
    else $error("watchdog timed out at wrong limit");
  a_dead_decode: assert property (@(posedge ref_clk) disable iff (reset)
    (st_reg.gatewd_reg[7:6] == 2'h3) |-> drive_cfg.dead_time_cycles == 8'h60)
    else $error("longest dead time wrong");
  a_monitor_off: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && !locked && idx == GDCFG_IDX_DRAIN && wb_req.dat[3]) |=>
      !drive_cfg.monitor_enable[3])
    else $error("monitor not disabled");
  a_regulation_off: assert property (@(posedge ref_clk) disable iff (reset)
    st_reg.chop_reg[5] |-> !drive_cfg.regulation_on)
    else $error("regulation on while disabled");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (reset)
    (st_reg.mask_reg == 2'h0) |-> !irq)
    else $error("masked interrupt raised");
  a_gatewd_locked: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && locked && idx == GDCFG_IDX_GATEWD) |=> $stable(st_reg.gatewd_reg))
    else $error("gate register changed while locked");
  a_chop_locked: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && locked && idx == GDCFG_IDX_CHOP) |=> $stable(st_reg.chop_reg))
    else $error("chop register changed while locked");
  a_gate_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && !locked && idx == GDCFG_IDX_GATEWD) |=>
      drive_cfg.gate_current_sel == $past(wb_req.dat[2:0]))
    else $error("gate current write lost");
  a_gain_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && !locked && idx == GDCFG_IDX_CHOP) |=>
      drive_cfg.amp_gain_sel == $past(wb_req.dat[1:0]))
    else $error("gain write lost");
  a_fault_on_timeout: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wd_timeout) |=> wdog_fault)
    else $error("timeout did not raise fault");
  // ack is a single pulse; a held stb must not be taken twice
  a_ack_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wb_ack_o) |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_unmapped: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && req && !hit) |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");
  a_stat_read_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && req && hit && !wb_req.we && idx == GDCFG_IDX_STAT && events == 2'h0) |=>
      st_reg.stat_reg == 2'h0)
    else $error("status not cleared by read");
endmodule : gdcfg_regs
`default_nettype wire

// ==== verilog/gdcfg_pkg.sv ====
// package: register map, field layout, reset values and timing constants of the gate driver config bank
`default_nettype none
package gdcfg_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] GDCFG_IDX_MAIN   = 8'h02;
  localparam logic [7:0] GDCFG_IDX_GATEWD = 8'h03;
  localparam logic [7:0] GDCFG_IDX_DRAIN  = 8'h04;
  localparam logic [7:0] GDCFG_IDX_CHOP   = 8'h05;
  localparam logic [7:0] GDCFG_IDX_STAT   = 8'h06;
  localparam logic [7:0] GDCFG_IDX_MASK   = 8'h07;
  localparam logic [7:0] GDCFG_IDX_WDKICK = 8'h08;
  localparam logic [7:0] GDCFG_IDX_LIVE   = 8'h09;

  localparam logic [7:0] GDCFG_RST_MAIN   = 8'h18;
  localparam logic [7:0] GDCFG_RST_GATEWD = 8'h07;
  localparam logic [7:0] GDCFG_RST_DRAIN  = 8'h70;
  localparam logic [7:0] GDCFG_RST_CHOP   = 8'h01;

  localparam logic [2:0] GDCFG_LOCK_CODE   = 3'h6;
  localparam logic [2:0] GDCFG_UNLOCK_CODE = 3'h3;
  localparam int         GDCFG_LOCK_LSB    = 3;

  // status / mask bit positions
  localparam int GDCFG_EV_WDOG   = 0;
  localparam int GDCFG_EV_LOCKED = 1;

  // timing, in milliseconds, microseconds and nanoseconds
  localparam int GDCFG_CLK_MHZ     = 100;
  localparam int GDCFG_CLK_NS      = 10;
  localparam int GDCFG_WD_MS_0     = 10;
  localparam int GDCFG_WD_MS_1     = 20;
  localparam int GDCFG_WD_MS_2     = 50;
  localparam int GDCFG_WD_MS_3     = 100;
  localparam int GDCFG_CHOP_OFF_TIME_SEL_US_0   = 25;
  localparam int GDCFG_CHOP_OFF_TIME_SEL_US_1   = 50;
  localparam int GDCFG_CHOP_OFF_TIME_SEL_US_2   = 100;
  localparam int GDCFG_CHOP_OFF_TIME_SEL_US_3   = 200;
  localparam int GDCFG_DEAD_NS_0   = 120;
  localparam int GDCFG_DEAD_NS_1   = 240;
  localparam int GDCFG_DEAD_NS_2   = 480;
  localparam int GDCFG_DEAD_NS_3   = 960;
  localparam int GDCFG_DEAD_CYC_0  = (GDCFG_DEAD_NS_0 + GDCFG_CLK_NS - 1) / GDCFG_CLK_NS;
  localparam int GDCFG_DEAD_CYC_1  = (GDCFG_DEAD_NS_1 + GDCFG_CLK_NS - 1) / GDCFG_CLK_NS;
  localparam int GDCFG_DEAD_CYC_2  = (GDCFG_DEAD_NS_2 + GDCFG_CLK_NS - 1) / GDCFG_CLK_NS;
  localparam int GDCFG_DEAD_CYC_3  = (GDCFG_DEAD_NS_3 + GDCFG_CLK_NS - 1) / GDCFG_CLK_NS;

  // decoded settings handed to the analog front end
  typedef struct packed {
    logic [7:0] dead_time_cycles;
    logic [2:0] gate_current_sel;
    logic       sense_out_clamp;
    logic [2:0] overcurrent_threshold_sel;
    logic [3:0] monitor_enable;  // {hb2_high, hb2_low, hb1_high, hb1_low}
    logic [1:0] chop_off_time_sel;
    logic       regulation_on;
    logic [1:0] vref_scale_sel;
    logic       sample_hold_enable;
    logic [1:0] amp_gain_sel;
  } gdcfg_drive_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } gdcfg_wb_req_t;

  typedef enum logic [0:0] {
    GDCFG_WD_IDLE = 1'b0,
    GDCFG_WD_RUN  = 1'b1
  } gdcfg_wd_state_t;
endpackage : gdcfg_pkg
`default_nettype wire

// ==== verification/gdcfg_bridge_model.sv ====
// partner model: external bridge consuming the decoded driver settings
`default_nettype none
module gdcfg_bridge_model (
  input  wire gdcfg_pkg::gdcfg_drive_t drive_cfg,
  output logic [15:0]                  dead_ns,
  output logic [2:0]                   n_monitored
);
  timeunit 1ns;
  timeprecision 1ns;
  import gdcfg_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // one design cycle is 10 ns, so the bridge sees the dead time in ns
  assign dead_ns = 16'(drive_cfg.dead_time_cycles) * 16'h000a;
  // each enabled monitor guards one fet; a disabled one leaves it unguarded
  assign n_monitored = 3'(drive_cfg.monitor_enable[0]) + 3'(drive_cfg.monitor_enable[1])
                     + 3'(drive_cfg.monitor_enable[2]) + 3'(drive_cfg.monitor_enable[3]);
endmodule : gdcfg_bridge_model
`default_nettype wire

// ==== verification/gdcfg_regs_tb.sv ====
// testbench: config fields, lock, watchdog and interrupt of the register bank
`default_nettype none
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, got, want); end end
module gdcfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gdcfg_pkg::*;
  logic          ref_clk = 1'b0;
  logic          reset = 1'b1;
  logic          clk_en = 1'b1;
  gdcfg_wb_req_t wb_req = '0;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o, wb_err_o, wdog_fault, irq, er;
  gdcfg_drive_t  drive_cfg, cfg_exp;
  logic [15:0]   dead_ns;
  logic [2:0]    n_monitored;
  logic [7:0]    rd;
  int            n_mismatch = 0;
  int            total_checks = 0;

  // short watchdog unit keeps the 100 ms case near 1000 cycles
  gdcfg_regs #(.WD_UNIT_CYCLES(10)) u_gdcfg_regs (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .drive_cfg(drive_cfg),
    .wdog_fault(wdog_fault), .irq(irq));
  gdcfg_bridge_model u_gdcfg_bridge_model (.drive_cfg(drive_cfg), .dead_ns(dead_ns), .n_monitored(n_monitored));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    wb_req <= '{adr: {22'h000000, idx, 2'h0}, dat: {24'h000000, wd}, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) n_mismatch++;
    rd = wb_dat_o[7:0];
    er = wb_err_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic t_reset;
    cfg_exp = '{8'h0c, 3'h7, 1'b0, 3'h7, 4'hf, 2'h0, 1'b1, 2'h0, 1'b0, 2'h1};
    `CHK(drive_cfg, cfg_exp)
    `CHK(wdog_fault, 1'b0)
    wb(1'b0, 8'h03, 8'h00);
    `CHK(rd, 8'h07)
    wb(1'b0, 8'h04, 8'h00);
    `CHK(rd, 8'h70)
    wb(1'b0, 8'h05, 8'h00);
    `CHK(rd, 8'h01)
  endtask : t_reset

  task automatic t_dead;
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h03, {c[1:0], 6'h07});
      `CHK(dead_ns, 16'h0078 << c)
      wb(1'b0, 8'h03, 8'h00);
      `CHK(rd, {c[1:0], 6'h07})
    end
  endtask : t_dead

  task automatic t_fields;
    wb(1'b1, 8'h04, 8'h8f);
    wb(1'b1, 8'h05, 8'hfe);
    wb(1'b1, 8'h03, 8'h00);
    cfg_exp = '{8'h0c, 3'h0, 1'b1, 3'h0, 4'h0, 2'h3, 1'b0, 2'h3, 1'b1, 2'h2};
    `CHK(drive_cfg, cfg_exp)
    `CHK(n_monitored, 3'h0)
    wb(1'b1, 8'h04, 8'h4a);
    wb(1'b1, 8'h05, 8'h49);
    cfg_exp = '{8'h0c, 3'h0, 1'b0, 3'h4, 4'h5, 2'h1, 1'b1, 2'h1, 1'b0, 2'h1};
    `CHK(drive_cfg, cfg_exp)
    `CHK(n_monitored, 3'h2)
  endtask : t_fields

  task automatic t_lock;
    wb(1'b1, 8'h07, 8'h03);
    wb(1'b1, 8'h02, 8'h30);
    wb(1'b1, 8'h03, 8'h55);
    wb(1'b0, 8'h03, 8'h00);
    `CHK(rd, 8'h00)
    `CHK(irq, 1'b1)
    wb(1'b0, 8'h06, 8'h00);
    `CHK(rd, 8'h02)
    `CHK(irq, 1'b0)
    // software unlocks before changing settings
    wb(1'b1, 8'h02, 8'h18);
    wb(1'b1, 8'h03, 8'h55);
    wb(1'b0, 8'h03, 8'h00);
    `CHK(rd, 8'h55)
    wb(1'b0, 8'h0a, 8'h00);
    `CHK(er, 1'b1)
  endtask : t_lock

  task automatic t_wdog;
    int n;
    int lim;
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h03, {3'h1, c[1:0], 3'h0});
      wb(1'b1, 8'h08, 8'h00);
      wb(1'b1, 8'h02, 8'h19);
      n = 0;
      while (wdog_fault !== 1'b1 && n < 1100) begin
        @(posedge ref_clk);
        n++;
      end
      lim = (c == 0) ? 100 : (c == 1) ? 200 : (c == 2) ? 500 : 1000;
      `CHK(n >= lim - 12 && n <= lim + 2, 1'b1)
      `CHK(irq, 1'b1)
      wb(1'b0, 8'h06, 8'h00);
      `CHK(rd[0], 1'b1)
    end
    // a disabled timer must never expire
    wb(1'b1, 8'h03, 8'h00);
    wb(1'b1, 8'h02, 8'h19);
    repeat (1200) @(posedge ref_clk);
    `CHK(wdog_fault, 1'b0)
  endtask : t_wdog

  // clock enable low: request stalls and settings stay frozen
  task automatic t_clken;
    clk_en <= 1'b0;
    wb_req <= '{adr: {22'h000000, GDCFG_IDX_GATEWD, 2'h0}, dat: 32'h00000005, sel: 4'hf, we: 1'b1,
                cyc: 1'b1, stb: 1'b1};
    repeat (3) @(posedge ref_clk);
    `CHK(wb_ack_o, 1'b0)
    `CHK(drive_cfg.gate_current_sel, 3'h0)
    clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(wb_ack_o, 1'b1)
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge ref_clk);
    `CHK(drive_cfg.gate_current_sel, 3'h5)
  endtask : t_clken
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_dead;
    t_fields;
    t_lock;
    t_wdog;
    t_clken;
    end_of_test;
  end

  // whole run needs about 3100 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test;
  end
endmodule : gdcfg_regs_tb
`default_nettype wire
